/* File: include/rpt_host_map.vh */
// constants for the repeater host controller: timing counts and command codes
// assumes a 250 MHz system clock and a standard-mode bus on the low side
`ifndef RPT_HOST_MAP_VH
`define RPT_HOST_MAP_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RPT_CLK_NS        4
`define RPT_EN_SU_NS      100
`define RPT_EN_HD_NS      100
`define RPT_EN_SU_CYC     ((`RPT_EN_SU_NS + `RPT_CLK_NS - 1) / `RPT_CLK_NS)
`define RPT_EN_HD_CYC     ((`RPT_EN_HD_NS + `RPT_CLK_NS - 1) / `RPT_CLK_NS)
`define RPT_QTR_NS        2500
`define RPT_QTR_CYC       (`RPT_QTR_NS / `RPT_CLK_NS)

// ----------------------------------------------------------------
// commands and reset values
// ----------------------------------------------------------------
`define RPT_CMD_START     2'h0
`define RPT_CMD_WRITE     2'h1
`define RPT_CMD_READ      2'h2
`define RPT_CMD_STOP      2'h3
`define RPT_EN_RST        1'b1

`endif

/* File: rtl/rpt_line_monitor.v */
// two-line bus monitor: synchronises clock and data pins, finds start and stop
// assumes open-drain lines that idle high and come from outside the clock domain
`default_nettype none

module rpt_line_monitor (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // raw pins
  input  wire       scl_pin,
  input  wire       sda_pin,
  // synchronised view
  output reg        scl_s_q,
  output reg        sda_s_q,
  output reg        busy_q,
  output reg        stop_q
);

  reg scl_m_q;
  reg sda_m_q;
  reg sda_p_q;

  // ----------------------------------------------------------------
  // two-stage synchronisers, then start/stop detection
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_m_q <= 1'b1;
      sda_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      busy_q  <= 1'b0;
      stop_q  <= 1'b0;
    end else begin
      scl_m_q <= scl_pin;
      sda_m_q <= sda_pin;
      scl_s_q <= scl_m_q;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      stop_q  <= scl_s_q & ~sda_p_q & sda_s_q;
      if (scl_s_q & sda_p_q & ~sda_s_q)
        busy_q <= 1'b1;                 // start seen
      else if (scl_s_q & ~sda_p_q & sda_s_q)
        busy_q <= 1'b0;                 // stop seen
    end
  end

endmodule // rpt_line_monitor

`default_nettype wire

/* File: rtl/rpt_host_ctrl.v */
// host controller for a level-shifting bus repeater: drives the enable pin and
// runs a bit-level bus master on the low-voltage segment
// assumes the repeater's high side is observed only; pins are open drain
`include "rpt_host_map.vh"
`default_nettype none

module rpt_host_ctrl (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // user command port
  input  wire       en_want,
  input  wire       cmd_valid,
  input  wire [1:0] cmd_code,
  input  wire       cmd_wbit,
  output reg        cmd_ready_q,
  output reg        rd_valid_q,
  output reg        rd_bit_q,
  output reg        en_state_q,
  // repeater enable pin
  output reg        repeater_enable_q,
  // low-side segment pins
  input  wire       low_side_clock_line_in,
  output reg        low_side_clock_line_out_q,
  output reg        low_side_clock_line_oe_n_q,
  input  wire       low_side_data_line_in,
  output reg        low_side_data_line_out_q,
  output reg        low_side_data_line_oe_n_q,
  // high-side segment pins, watched only
  input  wire       high_side_clock_line_in,
  input  wire       high_side_data_line_in
);

  localparam [1:0]  PH_LAST  = 2'h3;
  localparam [2:0]  S_IDLE   = 3'h0;
  localparam [2:0]  S_PEND   = 3'h1;
  localparam [2:0]  S_START  = 3'h2;
  localparam [2:0]  S_BIT    = 3'h3;
  localparam [2:0]  S_STOP   = 3'h4;
  localparam integer QTR_INT = `RPT_QTR_CYC;
  localparam integer SU_INT  = `RPT_EN_SU_CYC;
  localparam integer HD_INT  = `RPT_EN_HD_CYC;
  localparam [9:0]  QTR_CYC  = QTR_INT[9:0];
  localparam [5:0]  SU_CYC   = SU_INT[5:0];
  localparam [5:0]  HD_CYC   = HD_INT[5:0];

  wire       a_scl;
  wire       a_sda;
  wire       a_busy;
  wire       b_scl;
  wire       b_sda;
  wire       b_busy;
  reg  [9:0] div_q;
  reg        tick_q;
  reg  [2:0] state_q;
  reg  [1:0] ph_q;
  reg  [1:0] code_q;
  reg        wbit_q;
  reg        own_q;
  reg  [5:0] su_q;
  reg  [5:0] hd_q;
  wire       seg_idle;
  wire       su_done;

  // ----------------------------------------------------------------
  // segment monitors, one per side of the repeater
  // ----------------------------------------------------------------
  rpt_line_monitor u_mon_a (
    .clk     (clk),
    .rst     (rst),
    .scl_pin (low_side_clock_line_in),
    .sda_pin (low_side_data_line_in),
    .scl_s_q (a_scl),
    .sda_s_q (a_sda),
    .busy_q  (a_busy),
    .stop_q  ()
  );

  rpt_line_monitor u_mon_b (
    .clk     (clk),
    .rst     (rst),
    .scl_pin (high_side_clock_line_in),
    .sda_pin (high_side_data_line_in),
    .scl_s_q (b_scl),
    .sda_s_q (b_sda),
    .busy_q  (b_busy),
    .stop_q  ()
  );

  // both segments quiet and lines high; a high-side low counts as busy
  assign seg_idle = ~a_busy & ~b_busy & a_scl & a_sda & b_scl & b_sda;
  assign su_done  = (su_q == SU_CYC);

  // ----------------------------------------------------------------
  // quarter-bit enable divider
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q  <= 10'h000;
      tick_q <= 1'b0;
    end else if (div_q == QTR_CYC - 10'h001) begin
      div_q  <= 10'h000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 10'h001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // enable pin: setup and hold timers, change only when idle
  // a start still pending waits for enable, so enable may move then too
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      repeater_enable_q <= `RPT_EN_RST;
      en_state_q        <= `RPT_EN_RST;
      su_q              <= 6'h00;
      hd_q              <= HD_CYC;
    end else begin
      if (!repeater_enable_q)
        su_q <= 6'h00;
      else if (!su_done)
        su_q <= su_q + 6'h01;
      if (state_q == S_STOP)
        hd_q <= 6'h00;
      else if (hd_q != HD_CYC)
        hd_q <= hd_q + 6'h01;
      if (((state_q == S_IDLE) || (state_q == S_PEND)) && !own_q && seg_idle
          && (hd_q == HD_CYC) && (repeater_enable_q != en_want)) begin
        repeater_enable_q <= en_want;
        en_state_q        <= en_want;
      end
    end
  end

  // ----------------------------------------------------------------
  // bit-level master on the low side
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q                    <= S_IDLE;
      ph_q                       <= 2'h0;
      code_q                     <= `RPT_CMD_START;
      wbit_q                     <= 1'b1;
      own_q                      <= 1'b0;
      cmd_ready_q                <= 1'b1;
      rd_valid_q                 <= 1'b0;
      rd_bit_q                   <= 1'b0;
      low_side_clock_line_out_q  <= 1'b0;
      low_side_clock_line_oe_n_q <= 1'b1;
      low_side_data_line_out_q   <= 1'b0;
      low_side_data_line_oe_n_q  <= 1'b1;
    end else begin
      rd_valid_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (cmd_valid) begin
            cmd_ready_q <= 1'b0;
            code_q      <= cmd_code;
            wbit_q      <= (cmd_code == `RPT_CMD_READ) ? 1'b1 : cmd_wbit;
            ph_q        <= 2'h0;
            if (cmd_code == `RPT_CMD_START)
              state_q <= S_PEND;
            else if (cmd_code == `RPT_CMD_STOP)
              state_q <= S_STOP;
            else
              state_q <= S_BIT;
          end
        end
        S_PEND: begin
          // a fresh start waits for enable setup and a quiet bus
          if (repeater_enable_q && su_done && (own_q || seg_idle))
            state_q <= S_START;
        end
        default: begin
          if (tick_q) begin
            // high phase waits while anyone holds the clock low
            if (ph_q == 2'h2 && !a_scl) begin
              ph_q <= ph_q;
            end else begin
              ph_q <= ph_q + 2'h1;
              case (state_q)
                S_START: begin
                  case (ph_q)
                    2'h0: low_side_data_line_oe_n_q  <= 1'b1;
                    2'h1: low_side_clock_line_oe_n_q <= 1'b1;
                    2'h2: low_side_data_line_oe_n_q  <= 1'b0;
                    default: begin
                      low_side_clock_line_oe_n_q <= 1'b0;
                      own_q                      <= 1'b1;
                    end
                  endcase
                end
                S_BIT: begin
                  case (ph_q)
                    2'h0: low_side_data_line_oe_n_q  <= wbit_q;
                    2'h1: low_side_clock_line_oe_n_q <= 1'b1;
                    2'h2: begin
                      rd_bit_q   <= a_sda;
                      rd_valid_q <= (code_q == `RPT_CMD_READ);
                    end
                    default: low_side_clock_line_oe_n_q <= 1'b0;
                  endcase
                end
                default: begin
                  case (ph_q)
                    2'h0: low_side_data_line_oe_n_q  <= 1'b0;
                    2'h1: low_side_clock_line_oe_n_q <= 1'b1;
                    2'h2: low_side_data_line_oe_n_q  <= 1'b1;
                    default: own_q <= 1'b0;
                  endcase
                end
              endcase
              if (ph_q == PH_LAST) begin
                state_q     <= S_IDLE;
                cmd_ready_q <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

endmodule // rpt_host_ctrl

`default_nettype wire

/* File: bench/rpt_host_ctrl_assertions.sv */
// checker for the repeater host controller: enable pin and command port
// assumes a bind to rpt_host_ctrl; one clock domain
`default_nettype none
module rpt_host_ctrl_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command port
  input wire logic cmd_valid,
  input wire logic cmd_ready_q,
  input wire logic rd_valid_q,
  input wire logic en_state_q,
  // pins
  input wire logic repeater_enable_q,
  input wire logic low_side_clock_line_out_q,
  input wire logic low_side_clock_line_oe_n_q,
  input wire logic low_side_data_line_out_q,
  input wire logic low_side_data_line_oe_n_q,
  input wire logic low_side_clock_line_in,
  input wire logic low_side_data_line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [5:0] en_cnt_q;
  logic [5:0] idle_cnt_q;
  logic       idle;
  // segment idle: nothing pulled by us, both lines high
  assign idle = low_side_clock_line_oe_n_q && low_side_data_line_oe_n_q
    && low_side_clock_line_in && low_side_data_line_in;
  function automatic logic [5:0] sat(input logic [5:0] v);
    return (v == 6'h3F) ? v : v + 6'h01;
  endfunction
  // cycles with enable high and with the segment idle, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_cnt_q   <= 6'h3F;
      idle_cnt_q <= 6'h3F;
    end else begin
      en_cnt_q   <= repeater_enable_q ? sat(en_cnt_q) : 6'h00;
      idle_cnt_q <= idle ? sat(idle_cnt_q) : 6'h00;
    end
  end
  sequence start_s;
    $fell(low_side_data_line_oe_n_q) && low_side_clock_line_oe_n_q;
  endsequence
  a_en_quiet: assert property ($changed(repeater_enable_q) |-> $past(idle))
    else $error("enable moved while the segment was busy");
  a_en_setup: assert property (start_s |-> en_cnt_q >= 6'h19)
    else $error("start too soon after enable rose");
  a_en_hold: assert property ($fell(repeater_enable_q) |-> idle_cnt_q >= 6'h19)
    else $error("enable fell too soon after stop");
  a_en_copy: assert property (en_state_q == repeater_enable_q)
    else $error("enable state differs from pin");
  a_en_reset: assert property ($fell(rst) |-> repeater_enable_q && cmd_ready_q)
    else $error("wrong levels after reset");
  a_rd_pulse: assert property (rd_valid_q |=> !rd_valid_q)
    else $error("read valid longer than one cycle");
  a_cmd_take: assert property (cmd_valid && cmd_ready_q |=> !cmd_ready_q)
    else $error("ready stayed high after a command");
  a_od_low: assert property (!low_side_clock_line_out_q && !low_side_data_line_out_q)
    else $error("open drain output not low");
  c_start: cover property (start_s);
  c_read: cover property (rd_valid_q);
  c_en_off: cover property ($fell(repeater_enable_q));
endmodule // rpt_host_ctrl_chk
bind rpt_host_ctrl rpt_host_ctrl_chk i_rpt_host_ctrl_chk (.*);
`default_nettype wire

/* File: bench/rpt_repeater_model.sv */
// behavioural repeater joining the low-side and high-side segments
// assumes open-drain lines with pull-ups; lows pass as levels
`default_nettype none
module rpt_repeater_model (
  // control
  input  wire logic en_pin,
  input  wire logic pwr_ok,
  // low side: pulls by other drivers, pulls by this model
  input  wire logic a_clk_low,
  input  wire logic a_dat_low,
  output logic      a_clk_pull,
  output logic      a_dat_pull,
  // high side: external pulls and resulting levels
  input  wire logic b_clk_ext,
  input  wire logic b_dat_ext,
  output logic      b_clk_line,
  output logic      b_dat_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act;
  // a floating enable reads high; drivers off until powered
  assign act = (en_pin !== 1'b0) && pwr_ok;
  // only an external high-side low is forwarded, never our own buffered low
  assign a_clk_pull = act && b_clk_ext;
  assign a_dat_pull = act && b_dat_ext;
  // a low-side low makes the buffered low; release lets the pull-up win
  assign b_clk_line = !(b_clk_ext || (act && a_clk_low));
  assign b_dat_line = !(b_dat_ext || (act && a_dat_low));
endmodule // rpt_repeater_model
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the repeater host controller
// assumes the repeater model on the far side and a slave on the high side
`include "rpt_host_map.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, en_want = 1'b1, cmd_valid = 1'b0, cmd_wbit = 1'b0;
  logic [1:0] cmd_code = 2'h0;
  logic pwr_ok = 1'b0, b_dat_ext = 1'b0;
  logic rdy, rd_v, rd_b, en_st, en_pin, sc_o, sc_oe_n, sd_o, sd_oe_n;
  logic a_clk_pull, a_dat_pull, b_clk_line, b_dat_line;
  int errors = 0, checked = 0;
  int rd_pulses = 0;
  wire sc_line = !(!sc_oe_n || a_clk_pull);
  wire sd_line = !(!sd_oe_n || a_dat_pull);
  // clock
  always #2 clk = !clk;
  // count read-valid pulses
  always @(posedge clk) if (rd_v === 1'b1) rd_pulses++;
  rpt_host_ctrl i_rpt_host_ctrl (.clk(clk), .rst(rst), .en_want(en_want),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wbit(cmd_wbit),
    .cmd_ready_q(rdy), .rd_valid_q(rd_v), .rd_bit_q(rd_b), .en_state_q(en_st),
    .repeater_enable_q(en_pin), .low_side_clock_line_in(sc_line),
    .low_side_clock_line_out_q(sc_o), .low_side_clock_line_oe_n_q(sc_oe_n),
    .low_side_data_line_in(sd_line), .low_side_data_line_out_q(sd_o),
    .low_side_data_line_oe_n_q(sd_oe_n), .high_side_clock_line_in(b_clk_line),
    .high_side_data_line_in(b_dat_line));
  rpt_repeater_model i_rpt_repeater_model (.en_pin(en_pin), .pwr_ok(pwr_ok),
    .a_clk_low(!sc_oe_n), .a_dat_low(!sd_oe_n), .a_clk_pull(a_clk_pull),
    .a_dat_pull(a_dat_pull), .b_clk_ext(1'b0), .b_dat_ext(b_dat_ext),
    .b_clk_line(b_clk_line), .b_dat_line(b_dat_line));
  task automatic chk(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic issue(input logic [1:0] code, input logic wbit);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_wbit  <= wbit;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic wait_ready();
    int n = 0;
    tick(1);
    while (rdy !== 1'b1 && n < 6000) begin
      tick(1);
      n++;
    end
    chk("cmd_ready_q", 1'b1, rdy);
  endtask
  task automatic cmd(input logic [1:0] code, input logic wbit);
    issue(code, wbit);
    wait_ready();
  endtask
  task automatic set_en(input logic v);
    @(posedge clk) en_want <= v;
  endtask
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // start held off while the repeater is disabled, enable frozen in a transfer
  task automatic t_enable();
    set_en(1'b0);
    tick(3);
    chk("enable", 1'b0, en_pin);
    chk("en_state_q", 1'b0, en_st);
    issue(`RPT_CMD_START, 1'b0);
    tick(100);
    chk("data_oe_n", 1'b1, sd_oe_n);
    set_en(1'b1);
    wait_ready();
    chk("high_data", 1'b0, b_dat_line);
    chk("clock_oe_n", 1'b0, sc_oe_n);
    chk("high_clock", 1'b0, b_clk_line);
    set_en(1'b0);
    tick(50);
    chk("enable", 1'b1, en_pin);
    set_en(1'b1);
  endtask
  // one byte out, then acknowledge and a released read bit from the high side
  task automatic t_byte();
    logic [7:0] b = 8'hA5;
    for (int i = 7; i >= 0; i--) begin
      cmd(`RPT_CMD_WRITE, b[i]);
      chk("high_data", b[i], b_dat_line);
    end
    @(posedge clk) b_dat_ext <= 1'b1;
    cmd(`RPT_CMD_READ, 1'b1);
    chk("rd_bit_q", 1'b0, rd_b);
    chk("rd_valid_q", 1'b1, rd_pulses == 1);
    @(posedge clk) b_dat_ext <= 1'b0;
    cmd(`RPT_CMD_READ, 1'b1);
    chk("rd_bit_q", 1'b1, rd_b);
    chk("rd_valid_q", 1'b1, rd_pulses == 2);
  endtask
  // stop, then enable may drop only after the hold time
  task automatic t_stop();
    cmd(`RPT_CMD_START, 1'b0);
    cmd(`RPT_CMD_STOP, 1'b0);
    chk("high_data", 1'b1, b_dat_line);
    set_en(1'b0);
    tick(10);
    chk("enable", 1'b1, en_pin);
    tick(30);
    chk("enable", 1'b0, en_pin);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst    <= 1'b0;
    pwr_ok <= 1'b1;
    tick(1);
    chk("enable", 1'b1, en_pin);
    chk("data_oe_n", 1'b1, sd_oe_n);
    t_enable();
    t_byte();
    t_stop();
    report_and_stop();
  end
  // watchdog
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
